// ### design/dip_port_clocking.sv
// Purpose : Input data port capture and data-rate clock generation of a dual DAC
// Assumes : mclk_i is the fast internal clock; main clock pin is sampled
// Notes   : DAC core, filters and serial port protocol sit outside this block
//
// Overview of operation
// - Oscillator ratio equals interpolation rate times prescaler ratio.
// - Zero stuffing doubles the oscillator ratio.
// - Sleep switches off DAC currents only; exit resumes at once.
// - Power-down halts capture and clocks; register port stays usable.
// - Two-port mode captures both ports on each data clock rising edge.
// - PLL control bit 7 of register 4 turns the PLL off or on.
// - PLL off: pin select bit chooses shared pin or serial data pin.
// - PLL on: select bit picks lock or data clock; pin bit picks pin.
// - One-port mode turns port 2 top bits into select input, clock out.
// - One-port mode steers each word by the channel select level.
// - Select low loads I, select high loads Q, on interleaved clock rise.
// - Interleaved clock runs at twice the per-channel rate.
// - PLL on two-port: data clock out matches the main clock frequency.
// - PLL on two-port: ports captured on main clock rising edge.
// - Two-port filter input rate equals the per-port data rate.
// - DAC rate ratio is interpolation rate, doubled by zero stuffing.
// - Lock shows on the lock pin and in bit 1 of register 0.
// - PLL off two-port: data clock is main clock divided by the DAC rate ratio.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dip_port_clocking #(
  parameter int LOCK_EDGES = dip_pkg::LOCK_EDGES_DEFAULT
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // Pins from the source
  input  wire logic        main_clock_in_i,
  input  wire logic [15:0] port1_i,
  input  wire logic [15:0] port2_i,
  input  wire logic        serial_sdo_data_i,
  // Port 2 bit fifteen as a two-way pin
  output logic             port2_bit_fifteen_o,
  output logic             port2_bit_fifteen_oe_n_o,
  // Clock and lock pins
  output logic             data_rate_clock_out_o,
  output logic             serial_data_out_pin_o,
  // Samples towards the interpolation filters
  output logic [15:0]      i_sample_o,
  output logic [15:0]      q_sample_o,
  output logic             sample_valid_o,
  output logic             dac_out_en_o
);
  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] stat_ctrl_ff, filt_ctrl_ff, port_ctrl_ff, pin_ctrl_ff, pll_ctrl_ff;
  logic       locked_ff;
  logic [7:0] vco_ratio, dac_ratio;
  logic [1:0] interp_code, presc_code;
  logic       zstuff, one_port, pll_on, sleep, pdown;

  // Control writes; reserved bits stay zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stat_ctrl_ff <= dip_pkg::RST_CTRL;
      filt_ctrl_ff <= dip_pkg::RST_CTRL;
      port_ctrl_ff <= dip_pkg::RST_CTRL;
      pin_ctrl_ff  <= dip_pkg::RST_CTRL;
      pll_ctrl_ff  <= dip_pkg::RST_CTRL;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        dip_pkg::ADDR_STATUS_CTRL: stat_ctrl_ff <= reg_wdata_i & dip_pkg::MASK_STATUS_CTRL;
        dip_pkg::ADDR_FILTER_CTRL: filt_ctrl_ff <= reg_wdata_i & dip_pkg::MASK_FILTER_CTRL;
        dip_pkg::ADDR_PORT_CTRL:   port_ctrl_ff <= reg_wdata_i & dip_pkg::MASK_PORT_CTRL;
        dip_pkg::ADDR_PIN_CTRL:    pin_ctrl_ff  <= reg_wdata_i & dip_pkg::MASK_PIN_CTRL;
        dip_pkg::ADDR_PLL_CTRL:    pll_ctrl_ff  <= reg_wdata_i & dip_pkg::MASK_PLL_CTRL;
        default: ;
      endcase
    end
  end

  // Decoded modes; one-port has no 1x rate, so 1x is promoted to 2x
  assign one_port    = port_ctrl_ff[dip_pkg::ONEPORT_BIT];
  assign interp_code = (one_port && filt_ctrl_ff[dip_pkg::INTERP_LSB +: 2] == 2'd0) ?
                       2'd1 : filt_ctrl_ff[dip_pkg::INTERP_LSB +: 2];
  assign zstuff      = filt_ctrl_ff[dip_pkg::ZSTUFF_BIT];
  assign presc_code  = pll_ctrl_ff[dip_pkg::PRESC_LSB +: 2];
  assign pll_on      = pll_ctrl_ff[dip_pkg::PLLEN_BIT];
  assign sleep       = stat_ctrl_ff[dip_pkg::SLEEP_BIT];
  assign pdown       = stat_ctrl_ff[dip_pkg::PDOWN_BIT];
  // Shift counts reach 7, so the sums are widened to three bits first
  assign vco_ratio   = 8'h01 << (3'(interp_code) + 3'(presc_code) + 3'(zstuff));
  assign dac_ratio   = 8'h01 << (3'(interp_code) + 3'(zstuff));

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        dip_pkg::ADDR_STATUS_CTRL: reg_rdata_o <= stat_ctrl_ff |
                                   (8'({locked_ff}) << dip_pkg::LOCK_BIT);
        dip_pkg::ADDR_FILTER_CTRL: reg_rdata_o <= filt_ctrl_ff;
        dip_pkg::ADDR_PORT_CTRL:   reg_rdata_o <= port_ctrl_ff;
        dip_pkg::ADDR_PIN_CTRL:    reg_rdata_o <= pin_ctrl_ff;
        dip_pkg::ADDR_PLL_CTRL:    reg_rdata_o <= pll_ctrl_ff;
        dip_pkg::ADDR_VCO_RATIO:   reg_rdata_o <= vco_ratio;
        dip_pkg::ADDR_DAC_RATIO:   reg_rdata_o <= dac_ratio;
        default:                   reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0]  mclk_pin_ff;
  logic [15:0] p1_s1_ff, p1_s2_ff, p2_s1_ff, p2_s2_ff;
  logic        main_rise, main_edge;

  // Two flops before any logic; third flop only feeds edge detection
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mclk_pin_ff <= 3'h0;
      p1_s1_ff    <= 16'h0000;
      p1_s2_ff    <= 16'h0000;
      p2_s1_ff    <= 16'h0000;
      p2_s2_ff    <= 16'h0000;
    end else begin
      mclk_pin_ff <= {mclk_pin_ff[1:0], main_clock_in_i};
      p1_s1_ff    <= port1_i;
      p1_s2_ff    <= p1_s1_ff;
      p2_s1_ff    <= port2_i;
      p2_s2_ff    <= p2_s1_ff;
    end
  end
  assign main_rise = mclk_pin_ff[1] & ~mclk_pin_ff[2];
  assign main_edge = mclk_pin_ff[1] ^ mclk_pin_ff[2];

  // ****************************************************************
  // Common generated clock
  // ****************************************************************
  logic       gclk_ff, nxt_gclk, gclk_rise;
  logic       mid_edge;
  logic [7:0] gap_cnt_ff, edge_gap_ff;
  logic [3:0] half_cnt_ff;
  logic [3:0] half_len;

  // Half period in main clock edges; one-port halves it for the 2x word rate
  assign half_len = one_port ? 4'(dac_ratio >> 1) : 4'(dac_ratio);

  // Main half period in mclk cycles; its mid-point lets the PLL one-port
  // word clock run at twice the main clock without a faster reference
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gap_cnt_ff  <= 8'h00;
      edge_gap_ff <= 8'h00;
    end else if (main_edge) begin
      gap_cnt_ff  <= 8'h01;
      edge_gap_ff <= gap_cnt_ff;
    end else if (gap_cnt_ff != 8'hFF) begin
      gap_cnt_ff  <= gap_cnt_ff + 8'd1;
    end
  end
  assign mid_edge = !main_edge && (edge_gap_ff[7:1] != 7'h00) &&
                    (gap_cnt_ff == {1'b0, edge_gap_ff[7:1]});

  // One divider feeds every rate enable, keeping them phase aligned
  always_comb begin
    nxt_gclk = gclk_ff;
    if (pdown) begin
      nxt_gclk = 1'b0;
    end else if (pll_on && !one_port) begin
      nxt_gclk = mclk_pin_ff[1];
    end else if (pll_on) begin
      if (main_edge || mid_edge) nxt_gclk = ~gclk_ff;
    end else if (main_edge && half_cnt_ff == half_len - 4'd1) begin
      nxt_gclk = ~gclk_ff;
    end
  end
  assign gclk_rise = nxt_gclk & ~gclk_ff;

  // Edge counter of the divider; cleared on power-down or PLL path
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gclk_ff     <= 1'b0;
      half_cnt_ff <= 4'h0;
    end else begin
      gclk_ff <= nxt_gclk;
      if (pdown || pll_on) begin
        half_cnt_ff <= 4'h0;
      end else if (main_edge) begin
        half_cnt_ff <= (half_cnt_ff >= half_len - 4'd1) ? 4'h0 : half_cnt_ff + 4'd1;
      end
    end
  end

  // ****************************************************************
  // PLL lock model
  // ****************************************************************
  logic [15:0] lock_cnt_ff;

  // Lock after a fixed count of reference edges; lost when PLL is off
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lock_cnt_ff <= 16'h0000;
      locked_ff   <= 1'b0;
    end else if (!pll_on || pdown) begin
      lock_cnt_ff <= 16'h0000;
      locked_ff   <= 1'b0;
    end else if (main_rise && !locked_ff) begin
      lock_cnt_ff <= lock_cnt_ff + 16'd1;
      locked_ff   <= (lock_cnt_ff == 16'(LOCK_EDGES - 1));
    end
  end

  // ****************************************************************
  // Data capture and pairing
  // ****************************************************************
  logic [15:0] i_hold_ff, q_hold_ff;
  logic        sel_q;

  // Select taken from port 2 bit fourteen, optionally inverted
  assign sel_q = p2_s2_ff[14] ^ port_ctrl_ff[dip_pkg::IQINV_BIT];

  // Capture on the generated clock rising edge only
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      i_hold_ff      <= 16'h0000;
      q_hold_ff      <= 16'h0000;
      i_sample_o     <= 16'h0000;
      q_sample_o     <= 16'h0000;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= 1'b0;
      if (gclk_rise && !one_port) begin
        i_sample_o     <= p1_s2_ff;
        q_sample_o     <= p2_s2_ff;
        sample_valid_o <= 1'b1;
      end else if (gclk_rise && !sel_q) begin
        i_hold_ff <= p1_s2_ff;
        if (port_ctrl_ff[dip_pkg::PAIRQ_BIT]) begin
          i_sample_o     <= p1_s2_ff;
          q_sample_o     <= q_hold_ff;
          sample_valid_o <= 1'b1;
        end
      end else if (gclk_rise) begin
        q_hold_ff <= p1_s2_ff;
        if (!port_ctrl_ff[dip_pkg::PAIRQ_BIT]) begin
          i_sample_o     <= i_hold_ff;
          q_sample_o     <= p1_s2_ff;
          sample_valid_o <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic pin_src, use_sdo;

  // Lock indicator only when the PLL runs and clock output is not chosen
  assign pin_src = (pll_on && !filt_ctrl_ff[dip_pkg::CLKSEL_BIT]) ? locked_ff : gclk_ff;
  assign use_sdo = pin_ctrl_ff[dip_pkg::SDOSEL_BIT];

  // Registered pin outputs; sleep only gates DAC currents
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      data_rate_clock_out_o    <= 1'b0;
      serial_data_out_pin_o    <= 1'b0;
      port2_bit_fifteen_o      <= 1'b0;
      port2_bit_fifteen_oe_n_o <= 1'b1;
      dac_out_en_o             <= 1'b0;
    end else begin
      data_rate_clock_out_o    <= use_sdo ? 1'b0 : pin_src;
      serial_data_out_pin_o    <= use_sdo ? pin_src : serial_sdo_data_i;
      port2_bit_fifteen_o      <= one_port & gclk_ff;
      port2_bit_fifteen_oe_n_o <= ~one_port;
      dac_out_en_o             <= ~sleep & ~pdown;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sleep_gates_dac: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sleep || pdown) |=> !dac_out_en_o) else $error("DAC on during sleep");
  a_sleep_exit_fast: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(sleep) && !pdown |=> dac_out_en_o) else $error("slow sleep exit");
  a_pdown_stops_cap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pdown && $past(pdown) |-> !sample_valid_o) else $error("capture in power-down");
  a_pll_clock_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pll_on && !one_port && !pdown |=> gclk_ff == $past(mclk_pin_ff[1])) else
    $error("data clock not following main clock");
  a_two_port_capture: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    gclk_rise && !one_port |=> sample_valid_o && i_sample_o == $past(p1_s2_ff) &&
    q_sample_o == $past(p2_s2_ff)) else $error("two-port capture wrong");
  a_word_to_q: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    gclk_rise && one_port && sel_q |=> q_hold_ff == $past(p1_s2_ff)) else
    $error("Q word misrouted");
  a_word_to_i: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    gclk_rise && one_port && !sel_q |=> i_hold_ff == $past(p1_s2_ff)) else
    $error("I word misrouted");
  a_vco_ratio_val: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    vco_ratio == dac_ratio << presc_code) else $error("oscillator ratio wrong");
  a_lock_on_pin: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pll_on && !filt_ctrl_ff[dip_pkg::CLKSEL_BIT] && !use_sdo |=>
    data_rate_clock_out_o == $past(locked_ff)) else $error("lock not on pin");
  a_sdo_select: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pll_on && use_sdo |=> serial_data_out_pin_o == $past(gclk_ff) &&
    !data_rate_clock_out_o) else $error("clock not on serial pin");
  a_oneport_pin_dir: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    one_port |=> !port2_bit_fifteen_oe_n_o) else $error("clock pin not driven");
  c_two_port_sample: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    !one_port && sample_valid_o);
  c_one_port_pair: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    one_port && sample_valid_o);
  c_pll_locked: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(locked_ff));
endmodule : dip_port_clocking

// ### design/dip_pkg.sv
// Purpose : Constants for the dual DAC input port and clock control block
// Assumes : Registers are 8 bits wide on a plain strobe port
// Notes   : Bit positions and reset values live here only
package dip_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FILTER_CTRL = 4'h1;
  localparam logic [3:0] ADDR_PORT_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_PIN_CTRL    = 4'h3;
  localparam logic [3:0] ADDR_PLL_CTRL    = 4'h4;
  localparam logic [3:0] ADDR_VCO_RATIO   = 4'h5;
  localparam logic [3:0] ADDR_DAC_RATIO   = 4'h6;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LOCK_BIT      = 1;
  localparam int SLEEP_BIT     = 3;
  localparam int PDOWN_BIT     = 4;
  localparam int INTERP_LSB    = 6;
  localparam int ZSTUFF_BIT    = 3;
  localparam int CLKSEL_BIT    = 0;
  localparam int ONEPORT_BIT   = 6;
  localparam int IQINV_BIT     = 1;
  localparam int PAIRQ_BIT     = 0;
  localparam int SDOSEL_BIT    = 7;
  localparam int PLLEN_BIT     = 7;
  localparam int PRESC_LSB     = 5;
  // ****************************************************************
  // Writable masks and reset values
  // ****************************************************************
  localparam logic [7:0] MASK_STATUS_CTRL = 8'h18;
  localparam logic [7:0] MASK_FILTER_CTRL = 8'hC9;
  localparam logic [7:0] MASK_PORT_CTRL   = 8'h43;
  localparam logic [7:0] MASK_PIN_CTRL    = 8'h80;
  localparam logic [7:0] MASK_PLL_CTRL    = 8'hE0;
  localparam logic [7:0] RST_CTRL         = 8'h00;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int LOCK_EDGES_DEFAULT = 64;
endpackage : dip_pkg

// ### testbench/dip_source_model.sv
// Purpose : Sample source facing the port and clocking block
// Assumes : H_CYC mclk cycles per main clock half period
// Notes   : Words count up; word bit 0 doubles as the channel select
`timescale 1ns/1ps
module dip_source_model #(
  parameter int H_CYC = 6
) (
  // Clock and timing reference
  input  wire logic        mclk_i,
  input  wire logic        sync_i,
  // Pins towards the block
  output logic             main_clock_o,
  output logic [15:0]      port1_o,
  output logic [15:0]      port2_o
);
  int          cnt;
  logic        sync_q;
  logic [15:0] word;
  // ****************************************************************
  // Main clock and word stream
  // ****************************************************************
  // Start state
  initial begin
    main_clock_o = 1'b0;
    cnt          = 0;
    sync_q       = 1'b0;
    word         = 16'h0000;
  end
  // Kept slow against mclk_i so the two-flop sampler sees every edge
  always @(posedge mclk_i) begin
    cnt <= (cnt == H_CYC - 1) ? 0 : cnt + 1;
    if (cnt == H_CYC - 1) begin
      main_clock_o <= ~main_clock_o;
    end
  end
  // New word after a falling reference edge, stable around the next rise
  always @(posedge mclk_i) begin
    sync_q <= sync_i;
    if (sync_q && !sync_i) begin
      word <= word + 16'h0001;
    end
  end
  // Port 2 bit 14 carries the select in one-port mode
  assign port1_o = word;
  assign port2_o = {~word[15], word[0], ~word[13:0]};
endmodule : dip_source_model

// ### testbench/testbench.sv
// Purpose : Self-checking bench for the port and clocking block
// Assumes : Source model supplies main clock and sample words
// Notes   : LOCK_EDGES shortened to 4 to keep the run brief
`timescale 1ns/1ps
module testbench;
  localparam int H = 6;
  logic        mclk_i, rst_n_i, reg_wr_i, reg_rd_i, serial_sdo_data_i;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic [1:0]  sync_sel;
  logic [3:0]  pins_q;
  int          n_errors, comparisons, v;
  wire  [7:0]  reg_rdata_o;
  wire  [15:0] port1_i, p2_drv, i_sample_o, q_sample_o;
  wire         main_clk, port2_bit_fifteen_o, port2_bit_fifteen_oe_n_o;
  wire         data_rate_clock_out_o, serial_data_out_pin_o, sample_valid_o, dac_out_en_o;
  // Two-way pin: the block owns bit 15 while its enable is low
  wire  [15:0] port2_i = {port2_bit_fifteen_oe_n_o ? p2_drv[15] : port2_bit_fifteen_o,
                          p2_drv[14:0]};
  wire  [3:0]  pins = {port2_bit_fifteen_o, serial_data_out_pin_o, data_rate_clock_out_o,
                       main_clk};
  wire  [3:0]  rise = pins & ~pins_q;
  dip_port_clocking #(.LOCK_EDGES(4)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .main_clock_in_i(main_clk), .port1_i(port1_i),
    .port2_i(port2_i), .serial_sdo_data_i(serial_sdo_data_i),
    .port2_bit_fifteen_o(port2_bit_fifteen_o),
    .port2_bit_fifteen_oe_n_o(port2_bit_fifteen_oe_n_o),
    .data_rate_clock_out_o(data_rate_clock_out_o),
    .serial_data_out_pin_o(serial_data_out_pin_o), .i_sample_o(i_sample_o),
    .q_sample_o(q_sample_o), .sample_valid_o(sample_valid_o), .dac_out_en_o(dac_out_en_o));
  dip_source_model #(.H_CYC(H)) u_src (
    .mclk_i(mclk_i), .sync_i(pins[sync_sel]), .main_clock_o(main_clk),
    .port1_o(port1_i), .port2_o(p2_drv));
  // ****************************************************************
  // Clock, edge finder and tasks
  // ****************************************************************
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) pins_q <= pins;
  // Sample a settled cycle, away from the edge's own updates
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1;
    check(reg_rdata_o, e);
  endtask : rd
  // Bounded wait for a rising edge on one pin, cycles counted
  task automatic wait_rise(input int w, output int n);
    n = 0;
    do begin
      tick();
      n++;
    end while (rise[w] !== 1'b1 && n < 400);
  endtask : wait_rise
  // First interval skipped: a rate change may leave one odd period
  task automatic period(input int w, input int exp);
    int n;
    wait_rise(w, n);
    wait_rise(w, n);
    wait_rise(w, n);
    check(n, exp);
  endtask : period
  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (sample_valid_o !== 1'b1 && n < 400);
    check(sample_valid_o, 1'b1);
  endtask : wait_valid
  task automatic count_valid(input int c);
    v = 0;
    repeat (c) begin
      tick();
      if (sample_valid_o === 1'b1) v++;
    end
  endtask : count_valid
  task automatic twoport(input int n);
    repeat (n) begin
      wait_valid();
      check(i_sample_o, port1_i);
      check(q_sample_o, port2_i);
    end
  endtask : twoport
  // Words alternate select; the first pairs after a switch are skipped
  task automatic oneport(input logic inv, input logic pair);
    logic [15:0] lat, oth;
    logic        exp_b;
    exp_b = ~(pair ^ inv);
    wr(dip_pkg::ADDR_PORT_CTRL, {2'b01, 4'h0, inv, pair});
    for (int k = 0; k < 5; k++) begin
      wait_valid();
      lat = pair ? i_sample_o : q_sample_o;
      oth = pair ? q_sample_o : i_sample_o;
      if (k > 1) begin
        check(lat[0], exp_b);
        check(oth, lat - 16'h0001);
      end
    end
  endtask : oneport
  task automatic done(input string s);
    $display("Test %s finished, mismatches so far %0d", s, n_errors);
  endtask : done
  task automatic results();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // ****************************************************************
  // Test sequence and watchdog
  // ****************************************************************
  // Generous bound: the whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    results();
  end
  initial begin
    {mclk_i, rst_n_i, reg_wr_i, reg_rd_i, serial_sdo_data_i} = 5'h00;
    {reg_addr_i, reg_wdata_i, sync_sel, n_errors, comparisons} = '0;
    sync_sel = 2'h1;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[3:0], (a > 4 && a < 7) ? 8'h01 : 8'h00);
    for (int a = 0; a < 7; a++) wr(a[3:0], 8'hFF);
    rd(0, dip_pkg::MASK_STATUS_CTRL);
    rd(1, dip_pkg::MASK_FILTER_CTRL);
    rd(2, dip_pkg::MASK_PORT_CTRL);
    rd(3, dip_pkg::MASK_PIN_CTRL);
    rd(4, dip_pkg::MASK_PLL_CTRL);
    rd(5, 8'h80);
    rd(6, 8'h10);
    for (int a = 0; a < 5; a++) wr(a[3:0], 8'h00);
    wr(4, 8'h20);
    for (int i = 0; i < 8; i++) begin
      wr(1, {i[2:1], 2'b00, i[0], 3'b000});
      rd(5, 8'(1 << (i / 2 + 1 + i % 2)));
      rd(6, 8'(1 << (i / 2 + i % 2)));
    end
    done("registers");
    wr(4, 8'h00);
    wr(1, 8'h40);
    period(1, 4 * H);
    twoport(3);
    wr(1, 8'h48);
    period(1, 8 * H);
    wr(1, 8'h80);
    period(1, 8 * H);
    @(posedge mclk_i);
    serial_sdo_data_i <= 1'b1;
    tick();
    tick();
    check(serial_data_out_pin_o, 1'b1);
    wr(3, 8'h80);
    sync_sel <= 2'h2;
    period(2, 8 * H);
    check(data_rate_clock_out_o, 1'b0);
    wr(3, 8'h00);
    sync_sel <= 2'h1;
    done("pll off two-port");
    wr(0, 8'h08);
    tick();
    tick();
    check(dac_out_en_o, 1'b0);
    count_valid(100);
    check(v > 0, 1'b1);
    wr(0, 8'h00);
    tick();
    tick();
    check(dac_out_en_o, 1'b1);
    wr(0, 8'h10);
    count_valid(100);
    check(v, 0);
    rd(0, 8'h10);
    wr(0, 8'h00);
    repeat (50) tick();
    done("sleep and power-down");
    wr(4, 8'h80);
    rd(0, 8'h00);
    repeat (100) tick();
    rd(0, 8'h02);
    check(data_rate_clock_out_o, 1'b1);
    wr(3, 8'h80);
    tick();
    tick();
    check(serial_data_out_pin_o, 1'b1);
    check(data_rate_clock_out_o, 1'b0);
    wr(3, 8'h00);
    wr(1, 8'h41);
    sync_sel <= 2'h0;
    period(1, 2 * H);
    twoport(3);
    rd(6, 8'h02);
    done("pll on two-port");
    wr(4, 8'h00);
    wr(1, 8'h40);
    sync_sel <= 2'h3;
    wr(2, 8'h40);
    tick();
    check(port2_bit_fifteen_oe_n_o, 1'b0);
    period(3, 2 * H);
    for (int c = 0; c < 4; c++) oneport(c[1], c[0]);
    wr(4, 8'h80);
    period(3, H);
    wr(2, 8'h00);
    tick();
    tick();
    check(port2_bit_fifteen_oe_n_o, 1'b1);
    done("one-port");
    results();
  end
endmodule : testbench
